// file: inc/mcl_pkg.sv
// Notes on behaviour
// R1 - tx vlan option lets tagged frames out
// R2 - transmitter sends only while enabled
// R3 - tx jumbo option allows oversize frames
// R4 - tx gap adjust uses programmed gap length
// R5 - rx vlan option accepts tagged frames
// R6 - receiver accepts frames only while enabled
// R7 - rx fcs passing forwards fcs to client
// R8 - rx jumbo option accepts oversize frames
// R9 - rx check disable skips length/crc checks
// R10 - pause frames carry programmed pause address
// R11 - tx and rx flow control enabled separately
// R12 - half duplex selectable, shown read-only
// R13 - fixed speed advertises only that rate
// R14 - fixed duplex advertises only that mode; here only with a fixed speed, auto speed advertises both modes
// R15 - negotiate at power-up, reset, link loss
// R16 - restart advertises all or requested, renegotiates
// R17 - after negotiation, program mac to result
// R18 - speed indication withdrawn until mac set
// R19 - negotiation error reported as status
// R20 - link drop clears indication until relinked
// R21 - loopback needs full duplex from controller; this block has no loopback control
// R22 - no-cable status indication provided
// R23 - separate tx and rx reset requests
package mcl_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_TX_CFG   = 5'h00;
  localparam logic [4:0] OFS_RX_CFG   = 5'h04;
  localparam logic [4:0] OFS_FC_CFG   = 5'h08;
  localparam logic [4:0] OFS_PAUSE_LO = 5'h0C;
  localparam logic [4:0] OFS_PAUSE_HI = 5'h10;
  localparam logic [4:0] OFS_SPD_CFG  = 5'h14;
  localparam logic [4:0] OFS_SPD_STAT = 5'h18;
  localparam logic [4:0] OFS_CTRL     = 5'h1C;
  // tx/rx, flow control and speed config fields
  localparam int B_VLAN  = 0;
  localparam int B_EN    = 1;
  localparam int B_FCS   = 2;
  localparam int B_JUMBO = 3;
  localparam int B_HALF  = 4;
  localparam int B_IFGEN = 5;
  localparam int B_NOCHK = 5;
  localparam int B_IFGLO = 8;
  localparam int B_FCTX  = 0;
  localparam int B_FCRX  = 1;
  localparam int B_SPDHALF = 2;
  // control strobes
  localparam int B_TXRST = 0;
  localparam int B_RXRST = 1;
  localparam int B_ANRST = 2;
  // speed status fields
  localparam int B_VALID = 0;
  localparam int B_SPDLO = 1;
  localparam int B_FULL  = 3;
  localparam int B_ANERR = 4;
  localparam int B_NOCAB = 5;
  localparam int B_LINK  = 6;
  localparam logic [31:0] TX_CFG_RST = 32'h0000_0002;
  localparam logic [31:0] RX_CFG_RST = 32'h0000_0002;
  localparam logic [47:0] PAUSE_RST  = 48'h0000_0000_0000;
  // speed selection codes
  localparam logic [1:0] SEL_AUTO = 2'h0;
  localparam logic [1:0] SEL_1G   = 2'h1;
  localparam logic [1:0] SEL_100  = 2'h2;
  localparam logic [1:0] SEL_10   = 2'h3;
  // advertised rates {1g,100m,10m}
  localparam logic [2:0] ADV_ALL = 3'h7;
  localparam logic [2:0] ADV_1G  = 3'h4;
  localparam logic [2:0] ADV_100 = 3'h2;
  localparam logic [2:0] ADV_10  = 3'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    AN_START = 5'h01,
    AN_WAIT  = 5'h02,
    AN_SET   = 5'h04,
    AN_UP    = 5'h08,
    AN_HOLD  = 5'h10
  } mcl_an_st_t;
endpackage

// file: rtl/mcl_an_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module mcl_an_ctrl
  import mcl_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // requests from the register file
  input  wire logic       restart_req,
  input  wire logic [1:0] sel_speed,
  input  wire logic       sel_half,
  // phy status
  input  wire logic       phy_an_done,
  input  wire logic       phy_an_err,
  input  wire logic       phy_link_up,
  input  wire logic [1:0] phy_res_speed,
  input  wire logic       phy_res_full,
  // phy control and results
  output logic [2:0]      adv_speed,
  output logic            adv_full,
  output logic            adv_half,
  output logic            an_restart,
  output logic [1:0]      mac_speed,
  output logic            mac_full,
  output logic            spd_valid,
  output logic            an_err_evt
);
  mcl_an_st_t st_r, st_nxt;
  logic [2:0] adv_spd_r, adv_spd_nxt;
  logic       adv_full_r, adv_full_nxt, adv_half_r, adv_half_nxt;
  logic       rst_r, rst_nxt, valid_r, valid_nxt, err_r, err_nxt;
  logic [1:0] spd_r, spd_nxt;
  logic       full_r, full_nxt;

  always_comb begin
    st_nxt = st_r;
    adv_spd_nxt = adv_spd_r;
    adv_full_nxt = adv_full_r;
    adv_half_nxt = adv_half_r;
    rst_nxt = 1'b0;
    valid_nxt = valid_r;
    err_nxt = 1'b0;
    spd_nxt = spd_r;
    full_nxt = full_r;
    unique case (st_r)
      AN_START: begin
        unique case (sel_speed) // R13 R16
          SEL_1G:   adv_spd_nxt = ADV_1G;
          SEL_100:  adv_spd_nxt = ADV_100;
          SEL_10:   adv_spd_nxt = ADV_10;
          SEL_AUTO: adv_spd_nxt = ADV_ALL;
        endcase
        adv_full_nxt = (sel_speed == SEL_AUTO) || !sel_half; // R14
        adv_half_nxt = (sel_speed == SEL_AUTO) || sel_half;
        rst_nxt = 1'b1; // R16
        valid_nxt = 1'b0; // R18
        st_nxt = AN_WAIT;
      end
      AN_WAIT: if (phy_an_done) begin
        if (phy_an_err) begin
          err_nxt = 1'b1; // R19
          st_nxt = AN_HOLD;
        end else begin
          spd_nxt = phy_res_speed; // R17
          full_nxt = phy_res_full;
          st_nxt = AN_SET;
        end
      end
      AN_SET: begin
        valid_nxt = 1'b1; // R18
        st_nxt = AN_UP;
      end
      AN_UP: if (!phy_link_up) begin
        valid_nxt = 1'b0; // R20
        st_nxt = AN_START; // R15
      end
      AN_HOLD: ;
    endcase
    if (restart_req) begin
      valid_nxt = 1'b0; // R18
      st_nxt = AN_START; // R16
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= AN_START; // R15
      adv_spd_r <= ADV_ALL;
      adv_full_r <= 1'b1;
      adv_half_r <= 1'b1;
      rst_r <= 1'b0;
      valid_r <= 1'b0;
      err_r <= 1'b0;
      spd_r <= 2'h0;
      full_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      adv_spd_r <= adv_spd_nxt;
      adv_full_r <= adv_full_nxt;
      adv_half_r <= adv_half_nxt;
      rst_r <= rst_nxt;
      valid_r <= valid_nxt;
      err_r <= err_nxt;
      spd_r <= spd_nxt;
      full_r <= full_nxt;
    end
  end

  assign adv_speed = adv_spd_r;
  assign adv_full = adv_full_r;
  assign adv_half = adv_half_r;
  assign an_restart = rst_r;
  assign mac_speed = spd_r;
  assign mac_full = full_r;
  assign spd_valid = valid_r;
  assign an_err_evt = err_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence good_done_s;
    st_r == AN_WAIT && phy_an_done && !phy_an_err && !restart_req;
  endsequence
  adv_only_1g_a: assert property ( // R13
    st_r == AN_START && sel_speed == SEL_1G |=> adv_speed == ADV_1G)
    else $error("fixed 1g selection advertised other rates");
  restart_dark_a: assert property ( // R18
    an_restart |-> !spd_valid)
    else $error("speed shown during restart");
  valid_after_set_a: assert property ( // R17
    good_done_s |=> !spd_valid ##1 spd_valid && mac_speed == $past(phy_res_speed, 2))
    else $error("speed not shown two cycles after good negotiation");
  link_drop_a: assert property ( // R20
    st_r == AN_UP && !phy_link_up |=> !spd_valid ##1 an_restart)
    else $error("link loss not handled");
endmodule
`default_nettype wire

// file: rtl/mcl_top.sv
`timescale 1ns/1ps
`default_nettype none
module mcl_top
  import mcl_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // phy status
  input  wire logic              phy_an_done,
  input  wire logic              phy_an_err,
  input  wire logic              phy_link_up,
  input  wire logic [1:0]        phy_res_speed,
  input  wire logic              phy_res_full,
  input  wire logic              phy_no_cable,
  // phy control
  output logic [2:0]             phy_adv_speed,
  output logic                   phy_adv_full,
  output logic                   phy_adv_half,
  output logic                   phy_an_restart,
  // mac transmit controls
  output logic                   mac_tx_en,
  output logic                   mac_tx_vlan,
  output logic                   mac_tx_fcs,
  output logic                   mac_tx_jumbo,
  output logic                   mac_tx_ifg_en,
  output logic [7:0]             mac_tx_ifg_len,
  output logic                   mac_tx_rst,
  // mac receive controls
  output logic                   mac_rx_en,
  output logic                   mac_rx_vlan,
  output logic                   mac_rx_fcs,
  output logic                   mac_rx_jumbo,
  output logic                   mac_rx_nochk,
  output logic                   mac_rx_rst,
  // mac shared controls
  output logic                   mac_tx_fc_en,
  output logic                   mac_rx_fc_en,
  output logic [47:0]            mac_pause_addr,
  output logic                   mac_half_duplex,
  output logic [1:0]             mac_speed,
  output logic                   mac_speed_valid
);
  if (ADDR_W < 5 || ADDR_W > 32) begin : g_addr_chk
    $error("ADDR_W must lie in 5..32");
  end

  logic [31:0] tx_cfg_r, tx_cfg_nxt, rx_cfg_r, rx_cfg_nxt;
  logic [1:0]  fc_r, fc_nxt;
  logic [47:0] pause_r, pause_nxt;
  logic [2:0]  spd_cfg_r, spd_cfg_nxt;
  logic        err_r, err_nxt, nocab_r, nocab_nxt;
  logic        txrst_r, txrst_nxt, rxrst_r, rxrst_nxt;
  logic        anreq_r, anreq_nxt, half_r, half_nxt;
  logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [4:0]  awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic        awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic        arrdy_r, arrdy_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [2:0]  an_adv;
  logic        an_full, an_half, an_rst, an_valid, an_err;
  logic [1:0]  an_spd;
  logic        an_mfull;
  logic        do_wr;

  // true for a word-aligned address inside the register window
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [4:0] lo;
    lo = a[4:0];
    return (a >> 5) == '0 && lo[1:0] == 2'h0;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] rd_word(input logic [4:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      OFS_TX_CFG: begin
        v = tx_cfg_r;
        v[B_HALF] = half_r; // R12
      end
      OFS_RX_CFG: begin
        v = rx_cfg_r;
        v[B_HALF] = half_r; // R12
      end
      OFS_FC_CFG:   v[1:0] = fc_r;
      OFS_PAUSE_LO: v = pause_r[31:0];
      OFS_PAUSE_HI: v[15:0] = pause_r[47:32];
      OFS_SPD_CFG:  v[2:0] = spd_cfg_r;
      OFS_SPD_STAT: begin
        v[B_VALID] = an_valid;
        v[B_SPDLO +: 2] = an_spd;
        v[B_FULL] = an_mfull;
        v[B_ANERR] = err_r; // R19
        v[B_NOCAB] = nocab_r; // R22
        v[B_LINK] = phy_link_up;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  assign do_wr = aw_hold_r && w_hold_r && !bvalid_r;

  // bus slave and register file
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    ws_nxt = ws_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    tx_cfg_nxt = tx_cfg_r;
    rx_cfg_nxt = rx_cfg_r;
    fc_nxt = fc_r;
    pause_nxt = pause_r;
    spd_cfg_nxt = spd_cfg_r;
    err_nxt = err_r;
    txrst_nxt = 1'b0;
    rxrst_nxt = 1'b0;
    anreq_nxt = 1'b0;
    nocab_nxt = phy_no_cable; // R22
    half_nxt = !an_mfull; // R12
    if (s_axi_awvalid && awrdy_r) begin
      aw_hold_nxt = 1'b1;
      awa_nxt = mapped(s_axi_awaddr) ? s_axi_awaddr[4:0] : 5'h03;
    end
    if (s_axi_wvalid && wrdy_r) begin
      w_hold_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      unique case (awa_r)
        OFS_TX_CFG: tx_cfg_nxt = merge(tx_cfg_r, wd_r, ws_r); // R1 R2 R3 R4
        OFS_RX_CFG: rx_cfg_nxt = merge(rx_cfg_r, wd_r, ws_r); // R5 R6 R7 R8 R9
        OFS_FC_CFG: if (ws_r[0]) begin
          fc_nxt = wd_r[1:0]; // R11
        end
        OFS_PAUSE_LO: pause_nxt[31:0] = merge(pause_r[31:0], wd_r, ws_r); // R10
        OFS_PAUSE_HI: begin
          if (ws_r[0]) pause_nxt[39:32] = wd_r[7:0]; // R10
          if (ws_r[1]) pause_nxt[47:40] = wd_r[15:8];
        end
        OFS_SPD_CFG: if (ws_r[0]) begin
          spd_cfg_nxt = wd_r[2:0]; // R13 R14
        end
        OFS_SPD_STAT: if (ws_r[0] && wd_r[B_ANERR]) begin
          err_nxt = 1'b0;
        end
        OFS_CTRL: if (ws_r[0]) begin
          txrst_nxt = wd_r[B_TXRST]; // R23
          rxrst_nxt = wd_r[B_RXRST]; // R23
          anreq_nxt = wd_r[B_ANRST]; // R16
        end
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    // a path reset returns that path's settings to defaults
    if (txrst_r) begin
      tx_cfg_nxt = TX_CFG_RST; // R23
    end
    if (rxrst_r) begin
      rx_cfg_nxt = RX_CFG_RST; // R23
    end
    // a new error wins over a clear in the same cycle
    if (an_err) begin
      err_nxt = 1'b1; // R19
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && arrdy_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = mapped(s_axi_araddr) ? rd_word(s_axi_araddr[4:0])
                                       : 32'h0000_0000;
      rresp_nxt = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    awrdy_nxt = !aw_hold_nxt;
    wrdy_nxt = !w_hold_nxt;
    arrdy_nxt = !rvalid_nxt;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awa_r <= 5'h00;
      wd_r <= 32'h0000_0000;
      ws_r <= 4'h0;
      awrdy_r <= 1'b0;
      wrdy_r <= 1'b0;
      arrdy_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      tx_cfg_r <= TX_CFG_RST;
      rx_cfg_r <= RX_CFG_RST;
      fc_r <= 2'h0;
      pause_r <= PAUSE_RST;
      spd_cfg_r <= 3'h0;
      err_r <= 1'b0;
      nocab_r <= 1'b0;
      txrst_r <= 1'b0;
      rxrst_r <= 1'b0;
      anreq_r <= 1'b0;
      half_r <= 1'b0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      awrdy_r <= awrdy_nxt;
      wrdy_r <= wrdy_nxt;
      arrdy_r <= arrdy_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      tx_cfg_r <= tx_cfg_nxt;
      rx_cfg_r <= rx_cfg_nxt;
      fc_r <= fc_nxt;
      pause_r <= pause_nxt;
      spd_cfg_r <= spd_cfg_nxt;
      err_r <= err_nxt;
      nocab_r <= nocab_nxt;
      txrst_r <= txrst_nxt;
      rxrst_r <= rxrst_nxt;
      anreq_r <= anreq_nxt;
      half_r <= half_nxt;
    end
  end

  mcl_an_ctrl u_an (
    .clk           (clk),
    .srst          (srst),
    .restart_req   (anreq_r),
    .sel_speed     (spd_cfg_r[1:0]),
    .sel_half      (spd_cfg_r[B_SPDHALF]),
    .phy_an_done   (phy_an_done),
    .phy_an_err    (phy_an_err),
    .phy_link_up   (phy_link_up),
    .phy_res_speed (phy_res_speed),
    .phy_res_full  (phy_res_full),
    .adv_speed     (an_adv),
    .adv_full      (an_full),
    .adv_half      (an_half),
    .an_restart    (an_rst),
    .mac_speed     (an_spd),
    .mac_full      (an_mfull),
    .spd_valid     (an_valid),
    .an_err_evt    (an_err)
  );

  assign s_axi_awready = awrdy_r;
  assign s_axi_wready = wrdy_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arrdy_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign phy_adv_speed = an_adv;
  assign phy_adv_full = an_full;
  assign phy_adv_half = an_half;
  assign phy_an_restart = an_rst;
  assign mac_tx_en = tx_cfg_r[B_EN];
  assign mac_tx_vlan = tx_cfg_r[B_VLAN];
  assign mac_tx_fcs = tx_cfg_r[B_FCS];
  assign mac_tx_jumbo = tx_cfg_r[B_JUMBO];
  assign mac_tx_ifg_en = tx_cfg_r[B_IFGEN];
  assign mac_tx_ifg_len = tx_cfg_r[B_IFGLO +: 8];
  assign mac_tx_rst = txrst_r;
  assign mac_rx_en = rx_cfg_r[B_EN];
  assign mac_rx_vlan = rx_cfg_r[B_VLAN];
  assign mac_rx_fcs = rx_cfg_r[B_FCS];
  assign mac_rx_jumbo = rx_cfg_r[B_JUMBO];
  assign mac_rx_nochk = rx_cfg_r[B_NOCHK];
  assign mac_rx_rst = rxrst_r;
  assign mac_tx_fc_en = fc_r[B_FCTX];
  assign mac_rx_fc_en = fc_r[B_FCRX];
  assign mac_pause_addr = pause_r;
  assign mac_half_duplex = half_r;
  assign mac_speed = an_spd;
  assign mac_speed_valid = an_valid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence tx_wr_s;
    do_wr && awa_r == OFS_TX_CFG && ws_r[0];
  endsequence
  wr_resp_a: assert property ( // R2
    do_wr |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  tx_en_a: assert property ( // R2
    tx_wr_s |=> mac_tx_en == $past(wd_r[B_EN]))
    else $error("transmit enable does not follow write");
  rx_nochk_a: assert property ( // R9
    do_wr && awa_r == OFS_RX_CFG && ws_r[0]
      |=> mac_rx_nochk == $past(wd_r[B_NOCHK]))
    else $error("check disable does not follow write");
  tx_rst_a: assert property ( // R23
    mac_tx_rst |=> mac_tx_en && !mac_tx_vlan && $stable(rx_cfg_r))
    else $error("tx reset wrong or disturbed rx");
  err_sticky_a: assert property ( // R19
    an_err |=> err_r ##1 err_r)
    else $error("negotiation error not held");
  cable_a: assert property ( // R22
    nocab_r == $past(phy_no_cable))
    else $error("no-cable status stale");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rd_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
endmodule
`default_nettype wire

// file: tb/mcl_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcl_phy_model
  import mcl_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // from the block
  input  wire logic [2:0] adv_speed,
  input  wire logic       adv_full,
  input  wire logic       an_restart,
  // scenario controls
  input  wire logic       slow,
  input  wire logic       fail,
  input  wire logic       cable_out,
  // status to the block
  output logic            an_done,
  output logic            an_err,
  output logic            link_up,
  output logic [1:0]      res_speed,
  output logic            res_full,
  output logic            no_cable
);
  logic [3:0] cnt_r;
  assign link_up  = ~cable_out;
  assign no_cable = cable_out;
  // negotiation stalls while no cable, as a real line would
  always @(posedge clk) begin
    an_done <= 1'b0;
    if (srst) begin
      {cnt_r, an_err, res_speed, res_full} <= 8'h00;
    end else if (an_restart) begin
      cnt_r <= slow ? 4'hC : 4'h2;
    end else if (cnt_r != 4'h0 && link_up) begin
      cnt_r <= cnt_r - 4'h1;
      if (cnt_r == 4'h1) begin
        an_done   <= 1'b1;
        an_err    <= fail;
        res_speed <= adv_speed[2] ? SEL_1G :
                     adv_speed[1] ? SEL_100 : SEL_10;
        res_full  <= adv_full;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/test_mac_config_and_link_setup.sv
`timescale 1ns/1ps
`default_nettype none
module test_mac_config_and_link_setup;
  import mcl_pkg::*;
  logic clk = 1'b0, srst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, phy_an_done, phy_an_err, phy_link_up;
  logic [1:0] s_axi_bresp, s_axi_rresp, phy_res_speed, mac_speed, r, s;
  logic [2:0] phy_adv_speed;
  logic phy_res_full, phy_no_cable, phy_adv_full, phy_adv_half;
  logic phy_an_restart, mac_tx_en, mac_tx_vlan, mac_tx_fcs, mac_tx_jumbo;
  logic mac_tx_ifg_en, mac_tx_rst, mac_rx_en, mac_rx_vlan, mac_rx_fcs;
  logic mac_rx_jumbo, mac_rx_nochk, mac_rx_rst, mac_tx_fc_en, mac_rx_fc_en;
  logic mac_half_duplex, mac_speed_valid, h;
  logic [7:0] mac_tx_ifg_len;
  logic [47:0] mac_pause_addr;
  logic slow = 0, fail = 0, cable_out = 0;
  int mismatches = 0, n_compared = 0, cyc = 0, txp = 0, rxp = 0, i, k;
  logic [1:0] sels [4] = '{SEL_100, SEL_10, SEL_1G, SEL_AUTO};
  logic [2:0] advs [4] = '{ADV_100, ADV_10, ADV_1G, ADV_ALL};

  mcl_top #(.ADDR_W(8)) i_dut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .phy_an_done, .phy_an_err, .phy_link_up,
    .phy_res_speed, .phy_res_full, .phy_no_cable, .phy_adv_speed,
    .phy_adv_full, .phy_adv_half, .phy_an_restart, .mac_tx_en, .mac_tx_vlan,
    .mac_tx_fcs, .mac_tx_jumbo, .mac_tx_ifg_en, .mac_tx_ifg_len, .mac_tx_rst,
    .mac_rx_en, .mac_rx_vlan, .mac_rx_fcs, .mac_rx_jumbo, .mac_rx_nochk,
    .mac_rx_rst, .mac_tx_fc_en, .mac_rx_fc_en, .mac_pause_addr,
    .mac_half_duplex, .mac_speed, .mac_speed_valid);

  mcl_phy_model i_phy (.clk, .srst, .adv_speed(phy_adv_speed),
    .adv_full(phy_adv_full), .an_restart(phy_an_restart), .slow, .fail,
    .cable_out, .an_done(phy_an_done), .an_err(phy_an_err),
    .link_up(phy_link_up), .res_speed(phy_res_speed),
    .res_full(phy_res_full), .no_cable(phy_no_cable));

  always #2.5 clk = ~clk;

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // path reset strobes are single pulses, so count them as they pass
  always @(posedge clk) begin
    cyc++;
    if (mac_tx_rst === 1'b1) txp++;
    if (mac_rx_rst === 1'b1) rxp++;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic chk(string nm, logic [47:0] seen, logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] v, output logic [1:0] rs);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      rs = s_axi_bresp;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      v = s_axi_rdata;
      rs = s_axi_rresp;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_valid;
    for (k = 0; k < 40 && mac_speed_valid !== 1'b1; k++) @(posedge clk);
    chk("speed_valid", mac_speed_valid, 1'b1);
  endtask

  task automatic wait_restart;
    for (k = 0; k < 10 && phy_an_restart !== 1'b1; k++) @(posedge clk);
    chk("an_restart", phy_an_restart, 1'b1);
    chk("valid_off", mac_speed_valid, 1'b0);
  endtask

  task automatic t_reset;
    wait_restart();
    chk("adv", {phy_adv_speed, phy_adv_full, phy_adv_half}, 5'h1F);
    wait_valid();
    chk("speed", mac_speed, SEL_1G);
    rd(8'(OFS_TX_CFG), d, r);
    chk("tx_cfg", d, TX_CFG_RST);
    rd(8'(OFS_RX_CFG), d, r);
    chk("rx_cfg", d, RX_CFG_RST);
    $display("test reset done");
  endtask

  task automatic t_cfg;
    // half bit written high must not stick
    wr(8'(OFS_TX_CFG), 32'h5A3D, r);
    chk("bresp", r, RESP_OKAY);
    chk("tx_out", {mac_tx_en, mac_tx_vlan, mac_tx_fcs, mac_tx_jumbo,
        mac_tx_ifg_en, mac_tx_ifg_len}, 13'h0F5A);
    rd(8'(OFS_TX_CFG), d, r);
    chk("tx_rd", d, 32'h5A2D);
    wr(8'(OFS_RX_CFG), 32'h3D, r);
    chk("rx_out", {mac_rx_en, mac_rx_vlan, mac_rx_fcs, mac_rx_jumbo,
        mac_rx_nochk}, 5'h0F);
    rd(8'(OFS_RX_CFG), d, r);
    chk("rx_rd", d, 32'h2D);
    for (i = 0; i < 4; i++) begin
      wr(8'(OFS_FC_CFG), i, r);
      chk("fc", {mac_rx_fc_en, mac_tx_fc_en}, i[1:0]);
    end
    wr(8'(OFS_PAUSE_LO), 32'h3344_5566, r);
    wr(8'(OFS_PAUSE_HI), 32'h0000_1122, r);
    chk("pause", mac_pause_addr, 48'h1122_3344_5566);
    $display("test config done");
  endtask

  task automatic t_speed;
    for (i = 0; i < 4; i++) begin
      s = sels[i];
      h = (i == 0);
      slow <= i[0];
      wr(8'(OFS_SPD_CFG), {29'h0, h, s}, r);
      wr(8'(OFS_CTRL), 32'h4, r);
      wait_restart();
      chk("adv", {phy_adv_speed, phy_adv_full, phy_adv_half},
          {advs[i], !h || s == SEL_AUTO, h || s == SEL_AUTO});
      wait_valid();
      @(posedge clk);
      if (s == SEL_AUTO) s = SEL_1G;
      chk("speed", mac_speed, s);
      chk("half", mac_half_duplex, h);
      rd(8'(OFS_SPD_STAT), d, r);
      chk("stat", d[6:0], {3'b100, !h, s, 1'b1});
    end
    $display("test speed done");
  endtask

  task automatic t_err_link;
    fail <= 1'b1;
    wr(8'(OFS_CTRL), 32'h4, r);
    for (k = 0; k < 10 && d[4] !== 1'b1; k++) rd(8'(OFS_SPD_STAT), d, r);
    chk("an_err", {d[4], d[0]}, 2'b10);
    fail <= 1'b0;
    wr(8'(OFS_SPD_STAT), 32'h10, r);
    rd(8'(OFS_SPD_STAT), d, r);
    chk("err_clr", d[4], 1'b0);
    wr(8'(OFS_CTRL), 32'h4, r);
    wait_valid();
    cable_out <= 1'b1;
    for (k = 0; k < 5 && mac_speed_valid !== 1'b0; k++) @(posedge clk);
    chk("link_drop", mac_speed_valid, 1'b0);
    wait_restart();
    rd(8'(OFS_SPD_STAT), d, r);
    chk("no_cable", d[6:5], 2'b01);
    cable_out <= 1'b0;
    wait_valid();
    $display("test error and link done");
  endtask

  task automatic t_path_bus;
    wr(8'(OFS_CTRL), 32'h1, r);
    repeat (3) @(posedge clk);
    chk("rst_cnt", {txp[1:0], rxp[1:0]}, 4'h4);
    rd(8'(OFS_TX_CFG), d, r);
    chk("tx_dflt", d, TX_CFG_RST);
    rd(8'(OFS_RX_CFG), d, r);
    chk("rx_kept", d, 32'h2D);
    wr(8'(OFS_CTRL), 32'h2, r);
    repeat (3) @(posedge clk);
    chk("rx_rst", {txp[1:0], rxp[1:0], mac_rx_vlan}, 5'h0A);
    wr(8'h20, 32'hFFFF_FFFF, r);
    chk("wr_unmapped", r, RESP_SLVERR);
    rd(8'h1D, d, r);
    chk("rd_unmapped", {d, r}, {32'h0, RESP_SLVERR});
    rd(8'(OFS_CTRL), d, r);
    chk("ctrl_rd", {d, r}, {32'h0, RESP_OKAY});
    rd(8'(OFS_TX_CFG), d, r);
    chk("no_effect", d, TX_CFG_RST);
    $display("test path reset and bus done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_cfg();
    t_speed();
    t_err_link();
    t_path_bus();
    summarize();
  end
endmodule
`default_nettype wire
